// file: hw/facg_clk_div.sv
`timescale 1ns/1ns
// toggles output every (divider+offset) selected source edges, or on every edge when that sum is 0
module facg_clk_div #(parameter logic [6:0] OFFSET = 7'h01)
(
    input wire logic clk,
    input wire logic rst,
    facg_div_if.div dif
);
    logic [6:0] cnt_r;
    logic [6:0] cnt_nxt;
    logic tog_r;
    logic tog_nxt;
    logic edge_hit;
    logic [6:0] limit;

    always_comb
    begin
        // phase 1 = rising edge, 0 = falling edge (inverted)
        edge_hit = dif.phase_sel ? (dif.src_now & ~dif.src_prev) : (~dif.src_now & dif.src_prev); // R10 R11
        limit = {1'b0, dif.divider} + OFFSET;
        if (limit == 7'h00)
        begin
            limit = 7'h01;
        end
        cnt_nxt = cnt_r;
        tog_nxt = tog_r;
        if (edge_hit)
        begin
            if (cnt_r + 7'h01 >= limit)
            begin
                cnt_nxt = 7'h00;
                tog_nxt = ~tog_r;
            end
            else
            begin
                cnt_nxt = cnt_r + 7'h01;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_r <= 7'h00;
            tog_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            tog_r <= tog_nxt;
        end
    end

    assign dif.out_clk = tog_r;
    assign dif.out_edge = tog_nxt ^ tog_r;
endmodule

// file: hw/facg_div_if.sv
`timescale 1ns/1ns
interface facg_div_if;
    logic [5:0] divider;
    logic phase_sel;
    logic src_now;
    logic src_prev;
    logic out_clk;
    logic out_edge;
    modport ctl (output divider, output phase_sel, output src_now, output src_prev, input out_clk, input out_edge);
    modport div (input divider, input phase_sel, input src_now, input src_prev, output out_clk, output out_edge);
endinterface

// file: hw/facg_pkg.sv
package facg_pkg;
    typedef enum logic [2:0] {
        FACG_IDLE = 3'b001,
        FACG_RUN = 3'b010,
        FACG_HOLD = 3'b100
    } facg_lock_t;
    typedef logic [7:0] facg_byte_t;
endpackage

// file: hw/facg_regs.svh
`ifndef FACG_REGS_SVH
`define FACG_REGS_SVH
// Summary of operation
// [R01] lock audio clock samples to field rate
// [R02] synthesize master clock from crystal reference
// [R03] 18-bit clocks-per-field across three registers
// [R04] 22-bit nominal increment across three registers
// [R05] master output wired to master input externally
// [R06] derive bit clock and channel clock
// [R07] bit clock = master / 2(divider+1)
// [R08] channel clock = bit clock / 2(divider)
// [R09] audio controls at subaddresses 30h to 3Fh
// [R10] channel phase bit selects bit-clock edge
// [R11] serial phase bit selects master-clock edge
// [R12] trim increment from per-field count error

// ---------------------------------------------------------------
// subaddresses
// ---------------------------------------------------------------
`define FACG_ADDR_FIRST 8'h30
`define FACG_ADDR_LAST 8'h3f
`define FACG_ADDR_CPF0 8'h30
`define FACG_ADDR_CPF1 8'h31
`define FACG_ADDR_CPF2 8'h32
`define FACG_ADDR_NPI0 8'h34
`define FACG_ADDR_NPI1 8'h35
`define FACG_ADDR_NPI2 8'h36
`define FACG_ADDR_SERIAL_DIVIDER 8'h38
`define FACG_ADDR_CDIV 8'h39
`define FACG_ADDR_CTRL 8'h3a

// ---------------------------------------------------------------
// field layouts and reset values
// ---------------------------------------------------------------
`define FACG_CPF_W 18
`define FACG_NPI_W 22
`define FACG_DIV_W 6
`define FACG_ACC_W 23
`define FACG_CTRL_SERIAL_CLOCK_PHASE_SEL 0
`define FACG_CTRL_CHANNEL_CLOCK_PHASE_SEL 1
`define FACG_CTRL_OPEN 2
`define FACG_RST_BYTE 8'h00
`define FACG_RST_CTRL 8'h03
// trim gain: error is shifted right by this before adding
`define FACG_TRIM_SHIFT 4
`define FACG_TRIM_LIMIT 22'h000fff
`endif

// file: hw/facg_top.sv
`timescale 1ns/1ns
`include "facg_regs.svh"
module facg_top
(
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire logic FIELD_REF,
    input wire logic DIVIDER_MASTER_CLOCK_IN,
    output logic SYNTH_MASTER_CLOCK_OUT,
    output logic SERIAL_BIT_CLOCK_OUT,
    output logic CHANNEL_SELECT_CLOCK_OUT,
    output logic [17:0] FIELD_COUNT
);
    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    facg_pkg::facg_byte_t regs_r [0:15];
    facg_pkg::facg_byte_t regs_nxt [0:15];
    logic [3:0] idx;
    logic in_range;

    always_comb
    begin
        idx = REG_ADDR[3:0];
        in_range = (REG_ADDR >= `FACG_ADDR_FIRST) && (REG_ADDR <= `FACG_ADDR_LAST); // R09
        for (int i = 0; i < 16; i++)
        begin
            regs_nxt[i] = regs_r[i];
        end
        if (REG_WR && in_range)
        begin
            regs_nxt[idx] = REG_WDATA;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 16; g++)
        begin : g_reg
            always_ff @(posedge CORE_CLK)
            begin
                if (RESET)
                begin
                    regs_r[g] <= (g == 10) ? `FACG_RST_CTRL : `FACG_RST_BYTE;
                end
                else
                begin
                    regs_r[g] <= regs_nxt[g];
                end
            end
        end
    endgenerate

    logic [17:0] cpf;
    logic [21:0] npi;
    logic [5:0] serial_divider;
    logic [5:0] cdiv;
    logic [7:0] ctrl;
    // unused bits of partial bytes read as zero
    assign cpf = {regs_r[2][1:0], regs_r[1], regs_r[0]}; // R03
    assign npi = {regs_r[6][5:0], regs_r[5], regs_r[4]}; // R04
    assign serial_divider = regs_r[8][5:0];
    assign cdiv = regs_r[9][5:0];
    assign ctrl = regs_r[10];

    logic [7:0] rd_nxt;
    logic [7:0] rd_r;
    always_comb
    begin
        rd_nxt = 8'h00;
        if (in_range)
        begin
            case (idx)
                4'h2: rd_nxt = {6'h00, regs_r[2][1:0]};
                4'h6: rd_nxt = {2'h0, regs_r[6][5:0]};
                4'h8: rd_nxt = {2'h0, regs_r[8][5:0]};
                4'h9: rd_nxt = {2'h0, regs_r[9][5:0]};
                4'ha: rd_nxt = {5'h00, regs_r[10][2:0]};
                4'h0, 4'h1, 4'h4, 4'h5: rd_nxt = regs_r[idx];
                default: rd_nxt = 8'h00;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // phase accumulator synthesizer and field lock
    // ---------------------------------------------------------------
    // output toggles on accumulator carry: master = f_crystal*inc/2^24, one carry per
    // half period, so accumulator runs at crystal rate in the real part
    logic [22:0] acc_r;
    logic [22:0] acc_nxt;
    logic mclk_r;
    logic mclk_nxt;
    logic [21:0] inc_r;
    logic [21:0] inc_nxt;
    logic [17:0] cnt_r;
    logic [17:0] cnt_nxt;
    logic [17:0] last_r;
    logic [17:0] last_nxt;
    logic fref_r;
    logic fref_nxt;
    facg_pkg::facg_lock_t st_r;
    facg_pkg::facg_lock_t st_nxt;
    logic [23:0] sum;
    logic [22:0] work_inc;
    logic signed [19:0] err;
    logic signed [22:0] adj;
    logic signed [23:0] trimmed;
    logic field_edge;
    logic cnt_inc;

    always_comb
    begin
        field_edge = FIELD_REF & ~fref_r;
        fref_nxt = FIELD_REF;
        work_inc = (st_r == facg_pkg::FACG_RUN) ? {1'b0, inc_r} : {1'b0, npi};
        sum = {1'b0, acc_r} + {1'b0, work_inc}; // R02
        acc_nxt = sum[22:0];
        mclk_nxt = sum[23] ? ~mclk_r : mclk_r;
        // one count per master period, on its falling toggle
        cnt_inc = sum[23] & mclk_r;
        cnt_nxt = cnt_r;
        last_nxt = last_r;
        inc_nxt = inc_r;
        st_nxt = st_r;
        err = 20'sh00000;
        adj = 23'sh000000;
        trimmed = 24'sh000000;
        if (cnt_inc)
        begin
            cnt_nxt = cnt_r + 18'h00001;
        end
        case (st_r)
            facg_pkg::FACG_IDLE:
            begin
                inc_nxt = npi;
                if (field_edge)
                begin
                    // a clock landing on the field edge belongs to the new field
                    cnt_nxt = {17'h00000, cnt_inc};
                    st_nxt = ctrl[`FACG_CTRL_OPEN] ? facg_pkg::FACG_HOLD : facg_pkg::FACG_RUN;
                end
            end
            facg_pkg::FACG_RUN:
            begin
                if (ctrl[`FACG_CTRL_OPEN])
                begin
                    st_nxt = facg_pkg::FACG_HOLD;
                end
                else if (field_edge)
                begin
                    // positive error: too few clocks, speed up
                    err = $signed({2'b00, cpf}) - $signed({2'b00, cnt_r}); // R01 R12
                    adj = 23'($signed(err) >>> `FACG_TRIM_SHIFT);
                    trimmed = $signed({2'b00, inc_r}) + 24'(adj);
                    if (trimmed > $signed({2'b00, npi} + {2'b00, `FACG_TRIM_LIMIT}))
                    begin
                        inc_nxt = npi + `FACG_TRIM_LIMIT;
                    end
                    else if (trimmed < $signed({2'b00, npi} - {2'b00, `FACG_TRIM_LIMIT}) || trimmed < 0)
                    begin
                        inc_nxt = npi - `FACG_TRIM_LIMIT;
                    end
                    else
                    begin
                        inc_nxt = trimmed[21:0]; // R12
                    end
                    last_nxt = cnt_r;
                    cnt_nxt = {17'h00000, cnt_inc}; // R01
                end
            end
            facg_pkg::FACG_HOLD:
            begin
                inc_nxt = npi;
                if (!ctrl[`FACG_CTRL_OPEN])
                begin
                    st_nxt = facg_pkg::FACG_IDLE;
                end
                else if (field_edge)
                begin
                    last_nxt = cnt_r;
                    cnt_nxt = {17'h00000, cnt_inc};
                end
            end
            default:
            begin
                st_nxt = facg_pkg::FACG_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            acc_r <= 23'h000000;
            mclk_r <= 1'b0;
            inc_r <= 22'h000000;
            cnt_r <= 18'h00000;
            last_r <= 18'h00000;
            fref_r <= 1'b0;
            st_r <= facg_pkg::FACG_IDLE;
            rd_r <= 8'h00;
        end
        else
        begin
            acc_r <= acc_nxt;
            mclk_r <= mclk_nxt;
            inc_r <= inc_nxt;
            cnt_r <= cnt_nxt;
            last_r <= last_nxt;
            fref_r <= fref_nxt;
            st_r <= st_nxt;
            rd_r <= rd_nxt;
        end
    end

    // ---------------------------------------------------------------
    // divider chain from external master input
    // ---------------------------------------------------------------
    // master input is taken as synchronous; must be well under half CORE_CLK
    logic mxin_r;
    logic bclk_prev_r;
    facg_div_if bit_if ();
    facg_div_if chan_if ();

    assign bit_if.divider = serial_divider;
    assign bit_if.phase_sel = ctrl[`FACG_CTRL_SERIAL_CLOCK_PHASE_SEL];
    assign bit_if.src_now = DIVIDER_MASTER_CLOCK_IN; // R05 R06
    assign bit_if.src_prev = mxin_r;
    assign chan_if.divider = cdiv;
    assign chan_if.phase_sel = ctrl[`FACG_CTRL_CHANNEL_CLOCK_PHASE_SEL];
    assign chan_if.src_now = bit_if.out_clk; // R06
    assign chan_if.src_prev = bclk_prev_r;

    // toggle every serial_divider+1 edges: period 2*(serial_divider+1) master cycles
    facg_clk_div #(.OFFSET(7'h01)) u_bit_div // R07
    (
        .clk(CORE_CLK),
        .rst(RESET),
        .dif(bit_if)
    );

    // toggle every cdiv edges (every edge when cdiv is 0): period 2*cdiv bit clocks, 2 when cdiv is 0
    facg_clk_div #(.OFFSET(7'h00)) u_chan_div // R08
    (
        .clk(CORE_CLK),
        .rst(RESET),
        .dif(chan_if)
    );

    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            mxin_r <= 1'b0;
            bclk_prev_r <= 1'b0;
        end
        else
        begin
            mxin_r <= DIVIDER_MASTER_CLOCK_IN;
            bclk_prev_r <= bit_if.out_clk;
        end
    end

    assign REG_RDATA = rd_r;
    assign SYNTH_MASTER_CLOCK_OUT = mclk_r;
    assign SERIAL_BIT_CLOCK_OUT = bit_if.out_clk;
    assign CHANNEL_SELECT_CLOCK_OUT = chan_if.out_clk;
    assign FIELD_COUNT = last_r;
endmodule

// file: tb/facg_audio_sink.sv
`timescale 1ns/1ns
// standard wiring: synthesized clock fed straight back to the divider input
module facg_audio_sink
(
    input wire logic master_out,
    output logic master_in
);
    assign master_in = master_out;
endmodule

// file: tb/facg_top_monitor.sv
`timescale 1ns/1ns
module facg_top_monitor
(
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic DIVIDER_MASTER_CLOCK_IN,
    input wire logic SYNTH_MASTER_CLOCK_OUT,
    input wire logic SERIAL_BIT_CLOCK_OUT,
    input wire logic CHANNEL_SELECT_CLOCK_OUT
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    // ---------------------------------------------------------------
    // edge history
    // ---------------------------------------------------------------
    // phase bits shadowed from the write stream, so edges can be judged
    logic [1:0] ph_r;
    logic [1:0] ph_nxt;
    logic [1:0] mi_r;
    logic [1:0] sb_r;
    logic ms_sel;
    logic sb_sel;
    always_comb
    begin
        ph_nxt = ph_r;
        if (RESET)
            ph_nxt = 2'h3;
        else if (REG_WR && REG_ADDR == 8'h3a)
            ph_nxt = REG_WDATA[1:0];
    end
    always_ff @(posedge CORE_CLK)
    begin
        ph_r <= ph_nxt;
        mi_r <= {mi_r[0], DIVIDER_MASTER_CLOCK_IN};
        sb_r <= {sb_r[0], SERIAL_BIT_CLOCK_OUT};
    end
    // exact lag: source edge seen one edge earlier, output moves on the next
    assign ms_sel = ph_r[0] ? (mi_r[0] & ~mi_r[1]) : (~mi_r[0] & mi_r[1]);
    assign sb_sel = ph_r[1] ? (sb_r[0] & ~sb_r[1]) : (~sb_r[0] & sb_r[1]);
    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_wr_rd;
        REG_WR && REG_ADDR == 8'h30 ##1 !REG_WR && REG_ADDR == 8'h30;
    endsequence
    a_outside_reads_zero: assert property (!(REG_ADDR inside {[8'h30:8'h3f]}) |=> REG_RDATA == 8'h00)
        else $error("read outside window not zero");
    a_cpf_top_mask: assert property (REG_ADDR == 8'h32 |=> REG_RDATA[7:2] == 6'h00)
        else $error("clocks per field top byte unmasked");
    a_npi_top_mask: assert property (REG_ADDR == 8'h36 |=> REG_RDATA[7:6] == 2'h0)
        else $error("increment top byte unmasked");
    a_div_top_mask: assert property (REG_ADDR inside {8'h38, 8'h39} |=> REG_RDATA[7:6] == 2'h0)
        else $error("divider byte unmasked");
    a_write_readback: assert property (s_wr_rd |=> REG_RDATA == $past(REG_WDATA, 2))
        else $error("written byte not read back");
    a_reset_clears_out: assert property ($fell(RESET) |-> !SYNTH_MASTER_CLOCK_OUT && !SERIAL_BIT_CLOCK_OUT
        && !CHANNEL_SELECT_CLOCK_OUT)
        else $error("clock outputs not cleared by reset");
    a_bit_edge_sel: assert property ($changed(SERIAL_BIT_CLOCK_OUT) |-> ms_sel)
        else $error("bit clock moved off selected master edge");
    a_chan_edge_sel: assert property ($changed(CHANNEL_SELECT_CLOCK_OUT) |-> sb_sel)
        else $error("channel clock moved off selected bit edge");
    a_bit_needs_master: assert property ($stable(DIVIDER_MASTER_CLOCK_IN) [*6] |-> $stable(SERIAL_BIT_CLOCK_OUT))
        else $error("bit clock moved without master input");
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic CORE_CLK = 1'b0;
    logic RESET = 1'b1;
    logic REG_WR = 1'b0;
    logic FIELD_REF = 1'b0;
    logic [7:0] REG_ADDR = 8'h00;
    logic [7:0] REG_WDATA = 8'h00;
    logic [7:0] REG_RDATA;
    logic smo;
    logic dmi;
    logic sbo;
    logic cso;
    logic [17:0] FIELD_COUNT;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    facg_top u_facg_top (.CORE_CLK(CORE_CLK), .RESET(RESET), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .FIELD_REF(FIELD_REF), .DIVIDER_MASTER_CLOCK_IN(dmi),
        .SYNTH_MASTER_CLOCK_OUT(smo), .SERIAL_BIT_CLOCK_OUT(sbo), .CHANNEL_SELECT_CLOCK_OUT(cso),
        .FIELD_COUNT(FIELD_COUNT));
    facg_audio_sink u_facg_audio_sink (.master_out(smo), .master_in(dmi));
    initial
    begin
        forever #50 CORE_CLK = ~CORE_CLK;
    end
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task results;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // whole run needs about 9500 cycles
    always @(posedge CORE_CLK)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            err_total++;
            results();
        end
    end
    task chk(input string nm, input logic [17:0] e, input logic [17:0] g);
        total_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task rst;
        @(posedge CORE_CLK);
        RESET <= 1'b1;
        repeat (12) @(posedge CORE_CLK);
        RESET <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CORE_CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CORE_CLK);
        REG_WR <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        repeat (2) @(posedge CORE_CLK);
        #10;
        chk($sformatf("register %h", a), {10'h000, e}, {10'h000, REG_RDATA});
    endtask
    function automatic logic pick(input int s);
        return (s == 0) ? smo : (s == 1) ? sbo : cso;
    endfunction
    task rise(input int s, output int n);
        n = 0;
        while (pick(s) === 1'b1 && n < 3000)
        begin
            @(posedge CORE_CLK);
            n++;
        end
        while (pick(s) !== 1'b1 && n < 3000)
        begin
            @(posedge CORE_CLK);
            n++;
        end
    endtask
    task per(input int s, input int e);
        int n;
        int m;
        rise(s, n);
        rise(s, n);
        rise(s, m);
        chk($sformatf("period of clock %0d", s), e[17:0], 18'(n + m));
    endtask
    task field(input int k);
        repeat (k)
        begin
            @(posedge CORE_CLK);
            FIELD_REF <= 1'b1;
            repeat (4) @(posedge CORE_CLK);
            FIELD_REF <= 1'b0;
            repeat (795) @(posedge CORE_CLK);
        end
    endtask
    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    logic [7:0] ad [11] = '{8'h30, 8'h31, 8'h32, 8'h34, 8'h35, 8'h36, 8'h38, 8'h39, 8'h3a, 8'h2f, 8'h40};
    logic [7:0] rv [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
    logic [7:0] mk [9] = '{8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'h3f, 8'h3f, 8'h3f, 8'h07};
    // control byte, serial divider, channel divider
    int cf [3][3] = '{'{7, 0, 1}, '{7, 1, 2}, '{4, 3, 1}};
    initial
    begin
        int i;
        rst();
        for (i = 0; i < 11; i++)
            rd(ad[i], rv[i]);
        chk("clocks idle", 18'h0, {15'h0, smo, sbo, cso});
        $display("test register map done");
        for (i = 0; i < 9; i++)
        begin
            wr(ad[i], 8'hff);
            rd(ad[i], mk[i]);
        end
        wr(8'h40, 8'h55);
        rd(8'h40, 8'h00);
        $display("test field masks done");
        // increment 200000h: carry every 4 cycles, master period 8
        for (i = 0; i < 3; i++)
        begin
            rst();
            wr(8'h3a, 8'(cf[i][0]));
            wr(8'h38, 8'(cf[i][1]));
            wr(8'h39, 8'(cf[i][2]));
            wr(8'h36, 8'h20);
            per(0, 16);
            per(1, 32 * (cf[i][1] + 1));
            per(2, 64 * cf[i][2] * (cf[i][1] + 1));
        end
        $display("test divider chain done");
        for (i = 0; i < 2; i++)
        begin
            rst();
            wr(8'h3a, i ? 8'h03 : 8'h07);
            wr(8'h30, 8'h64);
            wr(8'h36, 8'h20);
            field(5);
            chk("field count", 18'd100, FIELD_COUNT);
        end
        $display("test field lock done");
        results();
    end
endmodule
bind facg_top facg_top_monitor u_facg_top_monitor (.CORE_CLK(CORE_CLK), .RESET(RESET), .REG_WR(REG_WR),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .DIVIDER_MASTER_CLOCK_IN(DIVIDER_MASTER_CLOCK_IN), .SYNTH_MASTER_CLOCK_OUT(SYNTH_MASTER_CLOCK_OUT),
    .SERIAL_BIT_CLOCK_OUT(SERIAL_BIT_CLOCK_OUT), .CHANNEL_SELECT_CLOCK_OUT(CHANNEL_SELECT_CLOCK_OUT));
